// [design/supply_monitor_adc_setup.sv]
`timescale 1ns/100ps
// Functional notes
// - averaging count bits 0/1 select averaging of sixteen conversions
// - sequence mode bits 1/0 run the selected channels repeatedly
// - both supply calibration bits set apply offset and gain correction, here unity gain and zero offset, leaving the word unchanged
// - aux alarm enabled when its disable bit is 0, disabled when 1; temp and core alarms always low
// - one conversion takes 26 converter clock cycles
// - converter clock is port clock divided by the eight-bit divisor
// - channel-select bits choose sequence members; 0401h gives cal and aux
// - averaging only on channels whose averaging-enable bit is set
// - aux upper limit from register 52h, lower from 56h
// - results are 16-bit words, 10-bit value MSB-justified
// - without port clock an internal oscillator keeps conversions going
// - without port clock the read-data bus is not updated
// - on internal oscillator alarms and busy keep working
// - aux result in status register 2 readable over the test port
// - zero input-mode registers mean no alternative input mode
// - zero acquisition registers mean no extended acquisition time
// - 7-bit port address driven outside, decoded inside
// - register contents returned on a 16-bit read-data output
// - three alarm outputs plus a 5-bit converted-channel output
// - 1-bit active-high reset; may be tied low
// - end-of-sequence pulses one port clock cycle per full pass
// - port strobe latches address and returns addressed register
// - channel output updated at end of conversion as busy falls
// - aux alarm high outside thresholds, low once back inside
module supply_monitor_adc_setup #(
    parameter int unsigned AVG_N      = supply_monitor_pkg::AVG_COUNT,
    parameter int unsigned CONV_N     = supply_monitor_pkg::CONV_CYCLES,
    parameter int unsigned RD_LAT     = supply_monitor_pkg::READ_LATENCY
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // port clock presence and internal oscillator tick
    input  wire logic        i_port_clock_present,
    input  wire logic        i_osc_tick,
    // reconfiguration port
    input  wire logic        i_port_strobe,
    input  wire logic        i_port_write_strobe,
    input  wire logic [6:0]  i_port_address,
    input  wire logic [15:0] i_port_wdata,
    output logic [15:0]      o_port_rdata,
    output logic             o_port_result_valid,
    // test access port read of the aux result
    output logic [15:0]      o_test_aux_result,
    // sampled analog values, 10-bit, one per sensor
    input  wire logic [9:0]  i_temp_sample,
    input  wire logic [9:0]  i_core_sample,
    input  wire logic [9:0]  i_aux_sample,
    // monitor outputs
    output logic [2:0]       o_alarm,
    output logic             o_busy,
    output logic             o_end_of_seq,
    output logic [4:0]       o_channel
);

    // ========================================================
    // configuration registers
    logic [15:0] cfg_avg_r;
    logic [15:0] cfg_seq_r;
    logic [15:0] cfg_div_r;
    logic [15:0] seq_sel_lo_r;
    logic [15:0] seq_sel_hi_r;
    logic [15:0] avg_en_lo_r;
    logic [15:0] avg_en_hi_r;
    logic [15:0] in_mode_lo_r;
    logic [15:0] in_mode_hi_r;
    logic [15:0] acq_lo_r;
    logic [15:0] acq_hi_r;
    logic [15:0] aux_upper_r;
    logic [15:0] aux_lower_r;
    logic [15:0] res_r [3];
    logic [31:0] sel_all;
    logic [31:0] avg_all;
    logic        wr;

    assign wr      = i_port_strobe && i_port_write_strobe
                     && i_port_clock_present;
    assign sel_all = {seq_sel_hi_r, seq_sel_lo_r};
    assign avg_all = {avg_en_hi_r, avg_en_lo_r};

    // port writes need the port clock, so they gate on presence
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_avg_r    <= supply_monitor_pkg::RST_CFG_AVG;
            cfg_seq_r    <= supply_monitor_pkg::RST_CFG_SEQ;
            cfg_div_r    <= supply_monitor_pkg::RST_CFG_DIV;
            seq_sel_lo_r <= supply_monitor_pkg::RST_SEQ_SEL_LO;
            seq_sel_hi_r <= supply_monitor_pkg::RST_ZERO;
            avg_en_lo_r  <= supply_monitor_pkg::RST_AVG_EN_LO;
            avg_en_hi_r  <= supply_monitor_pkg::RST_ZERO;
            in_mode_lo_r <= supply_monitor_pkg::RST_ZERO;
            in_mode_hi_r <= supply_monitor_pkg::RST_ZERO;
            acq_lo_r     <= supply_monitor_pkg::RST_ZERO;
            acq_hi_r     <= supply_monitor_pkg::RST_ZERO;
            aux_upper_r  <= supply_monitor_pkg::RST_AUX_UPPER;
            aux_lower_r  <= supply_monitor_pkg::RST_AUX_LOWER;
        end
        else if (wr)
        begin
            if (i_port_address == supply_monitor_pkg::ADDR_CFG_AVG)
                cfg_avg_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_CFG_SEQ)
                cfg_seq_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_CFG_DIV)
                cfg_div_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_SEQ_SEL_LO)
                seq_sel_lo_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_SEQ_SEL_HI)
                seq_sel_hi_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_AVG_EN_LO)
                avg_en_lo_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_AVG_EN_HI)
                avg_en_hi_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_IN_MODE_LO)
                in_mode_lo_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_IN_MODE_HI)
                in_mode_hi_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_ACQ_LO)
                acq_lo_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_ACQ_HI)
                acq_hi_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_AUX_UPPER)
                aux_upper_r <= i_port_wdata;
            else if (i_port_address == supply_monitor_pkg::ADDR_AUX_LOWER)
                aux_lower_r <= i_port_wdata;
        end
    end

    // ========================================================
    // decoded configuration fields
    logic       avg16;
    logic       seq_cont;
    logic       cal_on;
    logic [7:0] divisor;
    logic       tick;

    assign avg16 = !cfg_avg_r[supply_monitor_pkg::AVG_HI_BIT]
                   && cfg_avg_r[supply_monitor_pkg::AVG_LO_BIT];
    assign seq_cont = cfg_seq_r[supply_monitor_pkg::SEQ_HI_BIT]
                   && !cfg_seq_r[supply_monitor_pkg::SEQ_LO_BIT];
    assign cal_on = cfg_seq_r[supply_monitor_pkg::CAL_GAIN_BIT]
                   && cfg_seq_r[supply_monitor_pkg::CAL_OFS_BIT];
    assign divisor = cfg_div_r[supply_monitor_pkg::DIV_MSB:
                               supply_monitor_pkg::DIV_LSB];

    // ========================================================
    // converter clock divider; divisor below 2 treated as 2
    logic [7:0] div_cnt_r;
    logic       adc_tick;
    logic [7:0] div_limit;

    assign div_limit = (divisor < 8'h02) ? 8'h02 : divisor;
    assign adc_tick  = (div_cnt_r == div_limit - 8'h01);
    // without the port clock the oscillator ticks drive the converter
    assign tick = i_port_clock_present ? adc_tick : i_osc_tick;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            div_cnt_r <= 8'h00;
        else if (adc_tick)
            div_cnt_r <= 8'h00;
        else
            div_cnt_r <= div_cnt_r + 8'h01;
    end

    // ========================================================
    // channel sequencer: next selected channel after a given one, wrapping past channel bit 31
    function automatic logic [4:0] next_chan(input logic [4:0] cur,
                                             input logic [31:0] sel);
        logic [4:0] res;
        logic       found;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= 32; i++)
        begin
            if (!found && sel[5'(cur + 5'(i))])
            begin
                res   = 5'(cur + 5'(i));
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // first selected channel, used to detect wrap of a pass
    function automatic logic [4:0] first_chan(input logic [31:0] sel);
        logic [4:0] res;
        logic       found;
        res   = 5'h00;
        found = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            if (!found && sel[i])
            begin
                res   = 5'(i);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // map a sequencer bit to its mux channel number
    function automatic logic [4:0] mux_of(input logic [4:0] bitno);
        logic [4:0] m;
        m = 5'h1f;
        if (bitno == 5'd0)
            m = supply_monitor_pkg::CH_CAL;
        else if (bitno == 5'd8)
            m = supply_monitor_pkg::CH_TEMP;
        else if (bitno == 5'd9)
            m = supply_monitor_pkg::CH_CORE;
        else if (bitno == 5'd10)
            m = supply_monitor_pkg::CH_AUX;
        return m;
    endfunction

    // ========================================================
    // conversion engine
    logic [4:0] seq_bit_r;
    logic [4:0] conv_cnt_r;
    logic       busy_r;
    logic       conv_done;
    logic [4:0] nxt_bit;
    logic       pass_end;

    assign conv_done = busy_r && tick
                       && (conv_cnt_r == 5'(CONV_N - 1));
    assign nxt_bit  = seq_cont ? next_chan(seq_bit_r, sel_all)
                               : seq_bit_r;
    assign pass_end = conv_done && (nxt_bit <= seq_bit_r)
                      && (nxt_bit == first_chan(sel_all));

    // busy stays high through all 26 converter cycles of a conversion
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_r     <= 1'b0;
            conv_cnt_r <= 5'h00;
            seq_bit_r  <= 5'h00;
        end
        else if (tick)
        begin
            if (!busy_r)
            begin
                busy_r     <= 1'b1;
                conv_cnt_r <= 5'h00;
            end
            else if (conv_done)
            begin
                busy_r    <= 1'b0;
                seq_bit_r <= nxt_bit;
            end
            else
                conv_cnt_r <= conv_cnt_r + 5'h01;
        end
    end

    // ========================================================
    // sample conversion with optional correction and averaging
    logic [9:0]  raw;
    logic [15:0] acc_r [3];
    logic [3:0]  avg_cnt_r [3];
    logic [4:0]  mux;

    assign mux = mux_of(seq_bit_r);

    // calibration gain of unity here; correction just clears
    // the low pad bits, keeping the 10-bit value MSB-justified
    always_comb
    begin
        raw = 10'h000;
        if (mux == supply_monitor_pkg::CH_TEMP)
            raw = i_temp_sample;
        else if (mux == supply_monitor_pkg::CH_CORE)
            raw = i_core_sample;
        else if (mux == supply_monitor_pkg::CH_AUX)
            raw = i_aux_sample;
    end

    // in_mode and acquisition registers only stored: zero means
    // default unipolar input and standard acquisition
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_res
            logic avg_on;
            logic [15:0] word;
            logic [15:0] sum;
            assign avg_on = avg16 && avg_all[8 + g];
            // sixteen 10-bit codes fit in 14 bits, so no overflow
            assign sum = acc_r[g] + {6'h00, raw};
            assign word = cal_on ? {raw, 6'h00}
                                 : {raw, 6'h00} | 16'h0000;
            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                begin
                    res_r[g]     <= 16'h0000;
                    acc_r[g]     <= 16'h0000;
                    avg_cnt_r[g] <= 4'h0;
                end
                else if (conv_done && mux == 5'(g))
                begin
                    if (!avg_on)
                        res_r[g] <= word;
                    else if (avg_cnt_r[g] == 4'(AVG_N - 1))
                    begin
                        // mean of sixteen is the sum shifted down by four
                        res_r[g] <= {sum[13:4], 6'h00};
                        acc_r[g]     <= 16'h0000;
                        avg_cnt_r[g] <= 4'h0;
                    end
                    else
                    begin
                        acc_r[g]     <= acc_r[g] + {6'h00, raw};
                        avg_cnt_r[g] <= avg_cnt_r[g] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    // ========================================================
    // alarms, channel and end-of-sequence outputs
    logic [2:0] alarm_r;
    logic [4:0] chan_r;
    logic       eos_r;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            alarm_r <= 3'b000;
            chan_r  <= 5'h00;
            eos_r   <= 1'b0;
        end
        else
        begin
            eos_r <= pass_end;
            if (conv_done)
                chan_r <= mux;
            // compare against the stored aux result; disabled stay low
            alarm_r[supply_monitor_pkg::ALM_AUX_BIT] <=
                !cfg_seq_r[supply_monitor_pkg::ALM_AUX_DIS_BIT]
                && ((res_r[2] > aux_upper_r)
                    || (res_r[2] < aux_lower_r));
            alarm_r[supply_monitor_pkg::ALM_TEMP_BIT] <= 1'b0;
            alarm_r[supply_monitor_pkg::ALM_CORE_BIT] <= 1'b0;
        end
    end

    assign o_alarm      = alarm_r;
    assign o_busy       = busy_r;
    assign o_end_of_seq = eos_r;
    assign o_channel    = chan_r;
    assign o_test_aux_result = res_r[2];

    // ========================================================
    // read path: fixed latency from strobe to valid
    logic [6:0]        rd_addr_r;
    logic [RD_LAT-1:0] rd_pipe_r;
    logic [15:0]       rdata_r;
    logic [15:0]       rd_mux;

    always_comb
    begin
        rd_mux = 16'h0000;
        if (rd_addr_r == supply_monitor_pkg::ADDR_STATUS_TEMP)
            rd_mux = res_r[0];
        else if (rd_addr_r == supply_monitor_pkg::ADDR_STATUS_CORE)
            rd_mux = res_r[1];
        else if (rd_addr_r == supply_monitor_pkg::ADDR_STATUS_AUX)
            rd_mux = res_r[2];
        else if (rd_addr_r == supply_monitor_pkg::ADDR_CFG_AVG)
            rd_mux = cfg_avg_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_CFG_SEQ)
            rd_mux = cfg_seq_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_CFG_DIV)
            rd_mux = cfg_div_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_SEQ_SEL_LO)
            rd_mux = seq_sel_lo_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_SEQ_SEL_HI)
            rd_mux = seq_sel_hi_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_AVG_EN_LO)
            rd_mux = avg_en_lo_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_AVG_EN_HI)
            rd_mux = avg_en_hi_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_IN_MODE_LO)
            rd_mux = in_mode_lo_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_IN_MODE_HI)
            rd_mux = in_mode_hi_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_ACQ_LO)
            rd_mux = acq_lo_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_ACQ_HI)
            rd_mux = acq_hi_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_AUX_UPPER)
            rd_mux = aux_upper_r;
        else if (rd_addr_r == supply_monitor_pkg::ADDR_AUX_LOWER)
            rd_mux = aux_lower_r;
    end

    // data freezes while the port clock is missing
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_addr_r <= 7'h00;
            rd_pipe_r <= '0;
            rdata_r   <= 16'h0000;
        end
        else if (i_port_clock_present)
        begin
            if (i_port_strobe)
                rd_addr_r <= i_port_address;
            rd_pipe_r <= {rd_pipe_r[RD_LAT-2:0], i_port_strobe};
            if (rd_pipe_r[RD_LAT-2])
                rdata_r <= rd_mux;
        end
        else
            rd_pipe_r <= '0;
    end

    assign o_port_rdata        = rdata_r;
    assign o_port_result_valid = rd_pipe_r[RD_LAT-1];

endmodule

// [design/supply_monitor_pkg.sv]
package supply_monitor_pkg;

    // ========================================================
    // port geometry
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned ALARM_N = 3;

    // ========================================================
    // register addresses on the reconfiguration port
    localparam logic [6:0] ADDR_STATUS_TEMP   = 7'h00;
    localparam logic [6:0] ADDR_STATUS_CORE   = 7'h01;
    localparam logic [6:0] ADDR_STATUS_AUX    = 7'h02;
    localparam logic [6:0] ADDR_CFG_AVG       = 7'h40;
    localparam logic [6:0] ADDR_CFG_SEQ       = 7'h41;
    localparam logic [6:0] ADDR_CFG_DIV       = 7'h42;
    localparam logic [6:0] ADDR_SEQ_SEL_LO    = 7'h48;
    localparam logic [6:0] ADDR_SEQ_SEL_HI    = 7'h49;
    localparam logic [6:0] ADDR_AVG_EN_LO     = 7'h4a;
    localparam logic [6:0] ADDR_AVG_EN_HI     = 7'h4b;
    localparam logic [6:0] ADDR_IN_MODE_LO    = 7'h4c;
    localparam logic [6:0] ADDR_IN_MODE_HI    = 7'h4d;
    localparam logic [6:0] ADDR_ACQ_LO        = 7'h4e;
    localparam logic [6:0] ADDR_ACQ_HI        = 7'h4f;
    localparam logic [6:0] ADDR_AUX_UPPER     = 7'h52;
    localparam logic [6:0] ADDR_AUX_LOWER     = 7'h56;

    // ========================================================
    // reset values of the configuration registers
    localparam logic [15:0] RST_CFG_AVG    = 16'h1000;
    localparam logic [15:0] RST_CFG_SEQ    = 16'h20c7;
    localparam logic [15:0] RST_CFG_DIV    = 16'h0a00;
    localparam logic [15:0] RST_SEQ_SEL_LO = 16'h0401;
    localparam logic [15:0] RST_AVG_EN_LO  = 16'h0400;
    localparam logic [15:0] RST_ZERO       = 16'h0000;
    localparam logic [15:0] RST_AUX_UPPER  = 16'he000;
    localparam logic [15:0] RST_AUX_LOWER  = 16'hcaaa;

    // ========================================================
    // field positions
    localparam int unsigned AVG_HI_BIT  = 13;
    localparam int unsigned AVG_LO_BIT  = 12;
    localparam int unsigned SEQ_HI_BIT  = 13;
    localparam int unsigned SEQ_LO_BIT  = 12;
    localparam int unsigned CAL_GAIN_BIT = 7;
    localparam int unsigned CAL_OFS_BIT  = 6;
    localparam int unsigned ALM_TEMP_BIT = 0;
    localparam int unsigned ALM_CORE_BIT = 1;
    localparam int unsigned ALM_AUX_BIT  = 2;
    // aux disable bit sits one above the alarm output index
    localparam int unsigned ALM_AUX_DIS_BIT = 3;
    localparam int unsigned DIV_MSB      = 15;
    localparam int unsigned DIV_LSB      = 8;
    localparam int unsigned RES_W        = 10;

    // ========================================================
    // channel numbers and timing
    localparam logic [4:0]  CH_TEMP  = 5'h00;
    localparam logic [4:0]  CH_CORE  = 5'h01;
    localparam logic [4:0]  CH_AUX   = 5'h02;
    localparam logic [4:0]  CH_CAL   = 5'h08;
    localparam int unsigned CONV_CYCLES  = 26;
    localparam int unsigned AVG_COUNT    = 16;
    localparam int unsigned READ_LATENCY = 4;
    localparam int unsigned CLK_LOSS_CYCLES = 8;

    // ========================================================
    // types
    typedef enum logic [1:0] {
        SEQ_MODE_DEFAULT,
        SEQ_MODE_SINGLE_PASS,
        SEQ_MODE_CONTINUOUS,
        SEQ_MODE_SINGLE_CHANNEL
    } seq_mode_e;

    typedef struct packed {
        logic       strobe;
        logic       write;
        logic [6:0] addr;
        logic [15:0] wdata;
    } port_req_s;

    typedef struct packed {
        logic [2:0] alarm;
        logic       busy;
        logic       end_of_seq;
        logic [4:0] channel;
    } monitor_out_s;

endpackage

// [sim/fabric_port_model.sv]
`timescale 1ns/100ps
// ==================================
// user fabric side of the port
module fabric_port_model (
    input  wire logic                   i_clock,
    input  wire logic                   i_valid,
    input  wire logic [15:0]            i_rdata,
    output supply_monitor_pkg::port_req_s o_req
);
    // one strobe pulse; qualifiers held until the answer is seen or eight cycles pass without one
    task automatic access(input logic w, input logic [6:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        @(posedge i_clock);
        o_req <= '{1'b1, w, a, d};
        @(posedge i_clock);
        o_req.strobe <= 1'b0;
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++) @(negedge i_clock) ok = i_valid;
        q = i_rdata;
        // released qualifiers flip so stale values never look valid
        @(posedge i_clock);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    initial o_req = '0;
endmodule

// [sim/supply_monitor_adc_setup_chk.sv]
`timescale 1ns/100ps
// ==================================
// port and converter timing checks
module supply_monitor_chk (
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_port_clock_present,
    input wire logic        i_port_strobe,
    input wire logic [15:0] o_port_rdata,
    input wire logic        o_port_result_valid,
    input wire logic [2:0]  o_alarm,
    input wire logic        o_busy,
    input wire logic        o_end_of_seq,
    input wire logic [4:0]  o_channel
);
    // one domain only, so clock and reset are given once
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    a_read_answer_late: assert property (i_port_strobe &&
        i_port_clock_present |-> ##4 o_port_result_valid) else $error("late");
    a_valid_without_strobe: assert property (o_port_result_valid |->
        $past(i_port_strobe, 4)) else $error("valid without strobe");
    a_rdata_held: assert property (!o_port_result_valid |->
        $stable(o_port_rdata)) else $error("rdata moved without valid");
    a_no_port_answer: assert property (!i_port_clock_present |->
        !o_port_result_valid) else $error("answer with port clock gone");
    a_eos_one_cycle: assert property (o_end_of_seq |=>
        !o_end_of_seq) else $error("end of sequence too long");
    a_unused_alarms: assert property (o_alarm[1:0] == 2'b00)
        else $error("disabled alarm raised");
    a_busy_too_short: assert property ($rose(o_busy) |->
        o_busy [*8]) else $error("conversion too short");
    a_channel_at_fall: assert property ($changed(o_channel) |->
        !o_busy) else $error("channel moved during conversion");
endmodule
bind supply_monitor_adc_setup supply_monitor_chk CHK (.i_clock, .i_rst,
    .i_port_clock_present, .i_port_strobe, .o_port_rdata,
    .o_port_result_valid, .o_alarm, .o_busy, .o_end_of_seq, .o_channel);

// [sim/tb_top.sv]
`timescale 1ns/100ps
// ==================================
// bench: port accesses and aux supply levels
module tb_top;
    logic        i_clock, i_rst, present, osc_tick, valid, ok;
    logic [9:0]  aux;
    logic [15:0] rdata, aux_res, got, held;
    int          fail_count, tests_run, n;
    supply_monitor_pkg::port_req_s    req;
    wire supply_monitor_pkg::monitor_out_s mon;
    logic [6:0]  addr_tab [13] = '{7'h40, 7'h41, 7'h42, 7'h48, 7'h49,
        7'h4a, 7'h4b, 7'h4c, 7'h4d, 7'h4e, 7'h4f, 7'h52, 7'h56};
    logic [15:0] dflt_tab [13] = '{16'h1000, 16'h20c7, 16'h0a00, 16'h0401,
        16'h0000, 16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'he000, 16'hcaaa};
    supply_monitor_adc_setup DUT (.i_clock, .i_rst,
        .i_port_clock_present(present), .i_osc_tick(osc_tick),
        .i_port_strobe(req.strobe), .i_port_write_strobe(req.write),
        .i_port_address(req.addr), .i_port_wdata(req.wdata),
        .o_port_rdata(rdata), .o_port_result_valid(valid),
        .o_test_aux_result(aux_res), .i_temp_sample(10'h000),
        .i_core_sample(10'h000), .i_aux_sample(aux), .o_alarm(mon.alarm),
        .o_busy(mon.busy), .o_end_of_seq(mon.end_of_seq),
        .o_channel(mon.channel));
    fabric_port_model DRV (.i_clock, .i_valid(valid), .i_rdata(rdata),
        .o_req(req));
    // 50 MHz port clock
    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // oscillator ticks every other cycle, only without the port clock
    always @(posedge i_clock) osc_tick <= !present && !osc_tick;
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // bounded wait, sampled mid-cycle to stay clear of the edge
    task automatic wait_until(input int sel);
        for (n = 0; n < 20000; n++)
        begin
            @(negedge i_clock);
            if (sel == 0 && mon.end_of_seq === 1'b1) return;
            if (sel == 1 && mon.alarm[2] === 1'b1) return;
            if (sel == 2 && mon.alarm[2] === 1'b0) return;
            if (sel == 3 && aux_res === 16'hd540) return;
        end
        fail_count++;
        $display("unexpected at %0t: wait %0d timed out", $time, sel);
        tally_and_finish();
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {i_rst, present, osc_tick, aux} = {3'b110, 10'h355};
        fail_count = 0;
        tests_run = 0;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        for (int i = 0; i < 13; i++)
        begin
            DRV.access(1'b0, addr_tab[i], 16'h0000, got, ok);
            check(got, dflt_tab[i]);
            check({15'h0000, ok}, 16'h0001);
        end
        // unmapped place ignores writes; a plain register reads back
        DRV.access(1'b1, 7'h7f, 16'hffff, got, ok);
        DRV.access(1'b0, 7'h7f, 16'h0000, got, ok);
        check(got, 16'h0000);
        DRV.access(1'b1, 7'h4e, 16'h1234, got, ok);
        DRV.access(1'b0, 7'h4e, 16'h0000, got, ok);
        check(got, 16'h1234);
        DRV.access(1'b1, 7'h4e, 16'h0000, got, ok);
        // divisor of 2 keeps the averaging waits short
        DRV.access(1'b1, 7'h42, 16'h0200, got, ok);
        wait_until(0);
        check({11'h000, mon.channel}, 16'h0002);
        // next conversion: 26 converter ticks of two port clocks each
        for (n = 0; n < 100 && mon.busy !== 1'b1; n++) @(negedge i_clock);
        for (n = 0; n < 100 && mon.busy === 1'b1; n++) @(negedge i_clock);
        check(16'(n), 16'(2 * supply_monitor_pkg::CONV_CYCLES));
        wait_until(3);
        DRV.access(1'b0, 7'h02, 16'h0000, got, ok);
        check(got, 16'hd540);
        @(posedge i_clock);
        aux <= 10'h3bb;
        wait_until(1);
        // port clock gone: reads unanswered, alarm still tracks
        held = rdata;
        @(posedge i_clock);
        {present, aux} <= {1'b0, 10'h355};
        DRV.access(1'b0, 7'h02, 16'h0000, got, ok);
        check({15'h0000, ok}, 16'h0000);
        wait_until(2);
        check(rdata, held);
        @(posedge i_clock);
        {present, aux} <= {1'b1, 10'h3bb};
        DRV.access(1'b1, 7'h41, 16'h20cf, got, ok);
        for (n = 0; n < 4000 && mon.alarm === 3'b000; n++) @(negedge i_clock);
        check({13'h0000, mon.alarm}, 16'h0000);
        tally_and_finish();
    end
endmodule
